// *** fsi_pkg.sv ***
package fsi_pkg;
    // Bit positions of the status register
    localparam int ST_BUSY = 0;
    localparam int ST_WEL = 1;
    localparam int ST_BP_LO = 2;
    localparam int ST_BP_HI = 6;
    localparam int ST_LOCK_LO = 7;
    // Bit positions of the operation flag register
    localparam int FL_ADDR4 = 0;
    localparam int FL_PROT = 1;
    localparam int FL_PHELD = 2;
    localparam int FL_PFAIL = 4;
    localparam int FL_EFAIL = 5;
    localparam int FL_EHELD = 6;
    localparam int FL_READY = 7;
    // Bit positions of the upper address register
    localparam int UA_FIX = 7;
    localparam int UA_SEG_HI = 3;
    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] UPPER_RST = 8'h00;
    localparam logic [4:0] BP_RST = 5'h00;
    // Chunk size codes, configuration byte four bits 7..6
    localparam logic [1:0] CRC_OFF = 2'h3;
    localparam logic [1:0] CRC_16 = 2'h2;
    localparam logic [1:0] CRC_32 = 2'h1;
    localparam logic [1:0] CRC_64 = 2'h0;
    // Wrap codes of configuration byte seven
    localparam logic [7:0] WRAP_OFF = 8'hff;
    localparam logic [7:0] WRAP_64 = 8'hfe;
    localparam logic [7:0] WRAP_32 = 8'hfd;
    localparam logic [7:0] WRAP_16 = 8'hfc;
    // Configuration byte five value for four-byte addressing
    localparam logic [7:0] ADDR4_CFG = 8'hfe;
    // Correction pin delay in serial clock cycles
    localparam int CORR_DELAY_CYC = 2;
    localparam int DATA_LINES = 4;
    // Operation engine states
    typedef enum logic [2:0] {
        OP_IDLE,
        OP_PROG,
        OP_ERASE,
        OP_WRITE,
        OP_PHELD,
        OP_EHELD
    } fsi_op_t;
endpackage : fsi_pkg

// *** fsi_crc_chunk.sv ***
`timescale 1ns/1ps
module fsi_crc_chunk
    import fsi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic enable,
    input wire logic [1:0] sizeCode,
    input wire logic dataValid,
    input wire logic [fsi_pkg::DATA_LINES-1:0] dataLines,
    output logic crcValid,
    output logic [fsi_pkg::DATA_LINES-1:0] crcData
);
    logic [6:0] nibbleCnt_reg;
    logic [fsi_pkg::DATA_LINES-1:0] acc_reg;
    logic [6:0] lastNibble;
    logic [fsi_pkg::DATA_LINES-1:0] accNext;

    // Nibbles per chunk minus one, two nibbles per byte
    always_comb begin
        case (sizeCode)
            CRC_16: lastNibble = 7'd31;
            CRC_32: lastNibble = 7'd63;
            default: lastNibble = 7'd127;
        endcase
    end

    // Running XOR of each data line over the chunk
    assign accNext = acc_reg ^ dataLines;

    // Chunk position and accumulator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nibbleCnt_reg <= 7'd0;
            acc_reg <= '0;
        end else if (restart || !enable) begin
            nibbleCnt_reg <= 7'd0;
            acc_reg <= '0;
        end else if (dataValid) begin
            if (nibbleCnt_reg == lastNibble) begin
                nibbleCnt_reg <= 7'd0;
                acc_reg <= '0;
            end else begin
                nibbleCnt_reg <= nibbleCnt_reg + 7'd1;
                acc_reg <= accNext;
            end
        end
    end

    // Result after every complete chunk only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crcValid <= 1'b0;
            crcData <= '0;
        end else begin
            crcValid <= 1'b0;
            if (enable && !restart && dataValid &&
                nibbleCnt_reg == lastNibble) begin
                crcValid <= 1'b1;
                crcData <= accNext;
            end
        end
    end

    crc_off_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !crcValid)
        else $error("chunk result emitted while disabled");
endmodule : fsi_crc_chunk

// *** fsi_regs.sv ***
`timescale 1ns/1ps
// What this block does
// - Open-drain correction pin released; low through corrected 8-byte chunk after delay.
// - Read CRC only in double-rate mode, never in single-rate mode.
// - CRC enable and chunk size come from byte four bits 7..6.
// - Chunk lengths of 16, 32 or 64 bytes.
// - Wrapped read with CRC uses wrap length as chunk; restored afterwards.
// - Each CRC bit is the XOR of one data line over the chunk.
// - CRC after every complete chunk; host must read whole chunks.
// - Status bit 0 is busy during program, erase, status or config write.
// - Status bit 1 mirrors write enable latch; writes refused without it.
// - Five block-protect bits, writable unless hardware-locked, block program/erase.
// - Chip erase runs only when nothing is protected.
// - Lock-select low gates status writes by the write-protect pin.
// - Both lock selects set refuse status writes forever.
// - Flag bit 0 shows address width, zero for three bytes.
// - Flag bit 1 set on protected or OTP attempt; cleared on resume.
// - Flag bits 6 and 2 set on suspend; cleared on resume or reset.
// - Flag bits 4 and 5 show program/erase failure; cleared on resume.
// - Flag bit 7 shows whether a write cycle is in progress.
// - Upper address bits 3..0 by write command, used only in 3-byte mode.
// - Continuous read crosses segments without changing upper address.
// - Program and erase stay inside the selected segment; chip erase not.
// - Upper bit 7 set on any correction in last read; new read clears.
module fsi_regs
    import fsi_pkg::*;
#(
    parameter int CORR_DELAY = fsi_pkg::CORR_DELAY_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic writeProtect_n,
    input wire logic statusLockSelHi,
    input wire logic [7:0] cfgByte4,
    input wire logic [7:0] cfgByte5,
    input wire logic [7:0] cfgByte7,
    input wire logic dtrMode,
    input wire logic cmdWren,
    input wire logic cmdWrdi,
    input wire logic statusWriteCmd,
    input wire logic [7:0] statusWriteData,
    input wire logic cmdConfigWrite,
    input wire logic cmdProgram,
    input wire logic cmdOtpProgram,
    input wire logic otpLocked,
    input wire logic cmdSectorErase,
    input wire logic cmdBlockErase,
    input wire logic cmdChipErase,
    input wire logic [27:0] cmdAddr,
    input wire logic cmdSuspend,
    input wire logic cmdResume,
    input wire logic cmdSoftReset,
    input wire logic cmdEnter4Byte,
    input wire logic cmdExit4Byte,
    input wire logic cmdUpperWrite,
    input wire logic [7:0] cmdUpperData,
    input wire logic cmdRead,
    input wire logic cmdReadWrap,
    input wire logic progByte,
    input wire logic arrayDone,
    input wire logic arrayFail,
    input wire logic rdValid,
    input wire logic [fsi_pkg::DATA_LINES-1:0] rdLines,
    input wire logic granuleFix,
    output logic [7:0] statusProtectReg,
    output logic [7:0] operationFlagReg,
    output logic [7:0] upperAddressReg,
    output logic cmdAccept,
    output logic cmdRefuse,
    output logic [27:0] opAddr,
    output logic [27:0] progAddr,
    output logic [27:0] readAddr,
    output logic correctionSignal_n,
    output logic correctionSignalOe_n,
    output logic crcValid,
    output logic [fsi_pkg::DATA_LINES-1:0] crcData
);
    fsi_op_t op_reg;
    logic writeEnableLatch_reg;
    logic [4:0] blockProtect_reg;
    logic statusLockSelLo_reg;
    logic [6:0] flags_reg;
    logic [3:0] upperAddr_reg;
    logic singleFixFlag_reg;
    logic addr4_reg;
    logic wrapRead_reg;
    logic nibblePhase_reg;
    logic [3:0] delayCnt_reg;
    logic pinLow_reg;
    logic [27:0] fullAddr;
    logic statusWriteOk;
    logic progTry;
    logic eraseTry;
    logic protHit;
    logic otpHit;
    logic anyWrite;
    logic granuleStart;
    logic crcEnable;
    logic [1:0] chunkCode;

    // Protected region of one 64KB block
    function automatic logic blockProtected(input logic [4:0] bp,
                                            input logic [11:0] blk);
        logic [12:0] span;
        span = 13'd0;
        if (bp[3:0] >= 4'hd)
            blockProtected = 1'b1;
        else if (bp[3:0] == 4'h0)
            blockProtected = 1'b0;
        else begin
            span = 13'd1 << (bp[3:0] - 4'h1);
            if (bp[4])
                blockProtected = {1'b0, blk} < span;
            else
                blockProtected = {1'b0, blk} >= (13'h1000 - span);
        end
    endfunction : blockProtected

    // Chunk size code of a wrap setting
    function automatic logic [1:0] wrapChunk(input logic [7:0] wrapCfg);
        case (wrapCfg)
            WRAP_16: wrapChunk = CRC_16;
            WRAP_32: wrapChunk = CRC_32;
            default: wrapChunk = CRC_64;
        endcase
    endfunction : wrapChunk

    // Command address widened by the upper address in 3-byte mode
    assign fullAddr = addr4_reg ? cmdAddr :
        {upperAddr_reg, cmdAddr[23:0]};

    // Status write permission by lock selects and pin
    assign statusWriteOk = writeEnableLatch_reg &&
        !(statusLockSelLo_reg && statusLockSelHi) &&
        !(statusLockSelLo_reg && !statusLockSelHi &&
          !writeProtect_n);

    // Attempt decoding for program and erase
    assign progTry = cmdProgram || cmdOtpProgram;
    assign eraseTry = cmdSectorErase || cmdBlockErase || cmdChipErase;
    assign otpHit = cmdOtpProgram && otpLocked;
    always_comb begin
        if (cmdChipErase)
            protHit = blockProtect_reg[3:0] != 4'h0;
        else if (cmdOtpProgram)
            protHit = 1'b0;
        else
            protHit = blockProtected(blockProtect_reg,
                                     fullAddr[27:16]);
    end
    assign anyWrite = progTry || eraseTry || statusWriteCmd ||
        cmdConfigWrite;

    // Accept or refuse write-type commands
    always_comb begin
        cmdAccept = 1'b0;
        cmdRefuse = 1'b0;
        if (anyWrite) begin
            if (op_reg != OP_IDLE || !writeEnableLatch_reg)
                cmdRefuse = 1'b1;
            else if (statusWriteCmd && !statusWriteOk)
                cmdRefuse = 1'b1;
            else if ((progTry || eraseTry) && (protHit || otpHit))
                cmdRefuse = 1'b1;
            else
                cmdAccept = 1'b1;
        end
    end

    // Operation engine
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_reg <= OP_IDLE;
        end else if (cmdSoftReset) begin
            op_reg <= OP_IDLE;
        end else begin
            case (op_reg)
                OP_IDLE: begin
                    if (cmdAccept && progTry)
                        op_reg <= OP_PROG;
                    else if (cmdAccept && eraseTry)
                        op_reg <= OP_ERASE;
                    else if (cmdAccept)
                        op_reg <= OP_WRITE;
                end
                OP_PROG: begin
                    if (arrayDone || arrayFail)
                        op_reg <= OP_IDLE;
                    else if (cmdSuspend)
                        op_reg <= OP_PHELD;
                end
                OP_ERASE: begin
                    if (arrayDone || arrayFail)
                        op_reg <= OP_IDLE;
                    else if (cmdSuspend)
                        op_reg <= OP_EHELD;
                end
                OP_WRITE: begin
                    if (arrayDone)
                        op_reg <= OP_IDLE;
                end
                OP_PHELD: begin
                    if (cmdResume)
                        op_reg <= OP_PROG;
                end
                OP_EHELD: begin
                    if (cmdResume)
                        op_reg <= OP_ERASE;
                end
                default: op_reg <= OP_IDLE;
            endcase
        end
    end

    // Write enable latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            writeEnableLatch_reg <= 1'b0;
        else if (cmdSoftReset || cmdWrdi || cmdAccept)
            writeEnableLatch_reg <= 1'b0;
        else if (cmdWren)
            writeEnableLatch_reg <= 1'b1;
    end

    // Block protect and lock select low bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            blockProtect_reg <= BP_RST;
            statusLockSelLo_reg <= STATUS_RST[ST_LOCK_LO];
        end else if (cmdAccept && statusWriteCmd) begin
            blockProtect_reg <= statusWriteData[ST_BP_HI:ST_BP_LO];
            statusLockSelLo_reg <= statusWriteData[ST_LOCK_LO];
        end
    end

    // Suspend, failure and protection flags; set wins over clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= 7'h00;
        end else begin
            if (cmdSoftReset) begin
                flags_reg[FL_PHELD] <= 1'b0;
                flags_reg[FL_EHELD] <= 1'b0;
            end
            if (cmdResume && op_reg == OP_PHELD) begin
                flags_reg[FL_PHELD] <= 1'b0;
                flags_reg[FL_EHELD] <= 1'b0;
                flags_reg[FL_PFAIL] <= 1'b0;
                flags_reg[FL_PROT] <= 1'b0;
            end
            if (cmdResume && op_reg == OP_EHELD) begin
                flags_reg[FL_PHELD] <= 1'b0;
                flags_reg[FL_EHELD] <= 1'b0;
                flags_reg[FL_EFAIL] <= 1'b0;
                flags_reg[FL_PROT] <= 1'b0;
            end
            if (cmdSuspend && op_reg == OP_PROG && !arrayDone && !arrayFail)
                flags_reg[FL_PHELD] <= 1'b1;
            if (cmdSuspend && op_reg == OP_ERASE && !arrayDone && !arrayFail)
                flags_reg[FL_EHELD] <= 1'b1;
            if (op_reg == OP_IDLE && writeEnableLatch_reg &&
                (protHit || otpHit)) begin
                if (progTry) begin
                    flags_reg[FL_PROT] <= 1'b1;
                    flags_reg[FL_PFAIL] <= 1'b1;
                end
                if (eraseTry) begin
                    flags_reg[FL_PROT] <= 1'b1;
                    flags_reg[FL_EFAIL] <= 1'b1;
                end
            end
            if (arrayFail && op_reg == OP_PROG)
                flags_reg[FL_PFAIL] <= 1'b1;
            if (arrayFail && op_reg == OP_ERASE)
                flags_reg[FL_EFAIL] <= 1'b1;
        end
    end

    // Address width, from command or configuration byte five
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            addr4_reg <= 1'b0;
        else if (cmdEnter4Byte || cfgByte5 == ADDR4_CFG)
            addr4_reg <= 1'b1;
        else if (cmdExit4Byte || cmdSoftReset)
            addr4_reg <= 1'b0;
    end

    // Upper address bits, written regardless of address mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            upperAddr_reg <= UPPER_RST[UA_SEG_HI:0];
        else if (cmdSoftReset)
            upperAddr_reg <= UPPER_RST[UA_SEG_HI:0];
        else if (cmdUpperWrite)
            upperAddr_reg <= cmdUpperData[UA_SEG_HI:0];
    end

    // Single correction flag of the last read; set wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            singleFixFlag_reg <= 1'b0;
        else if (rdValid && granuleFix)
            singleFixFlag_reg <= 1'b1;
        else if (cmdRead || cmdSoftReset)
            singleFixFlag_reg <= 1'b0;
    end

    // Operation start address and program pointer within segment
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opAddr <= 28'h0;
            progAddr <= 28'h0;
        end else if (cmdAccept && (progTry || eraseTry)) begin
            opAddr <= cmdChipErase ? 28'h0 : fullAddr;
            progAddr <= fullAddr;
        end else if (progByte && op_reg == OP_PROG) begin
            progAddr <= {progAddr[27:24], progAddr[23:0] + 24'h1};
        end
    end

    // Read pointer; crosses segments, wraps inside wrap window
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readAddr <= 28'h0;
            nibblePhase_reg <= 1'b0;
            wrapRead_reg <= 1'b0;
        end else if (cmdRead) begin
            readAddr <= fullAddr;
            nibblePhase_reg <= 1'b0;
            wrapRead_reg <= cmdReadWrap && cfgByte7 != WRAP_OFF;
        end else if (rdValid) begin
            nibblePhase_reg <= !nibblePhase_reg;
            if (nibblePhase_reg) begin
                if (!wrapRead_reg)
                    readAddr <= readAddr + 28'h1;
                else if (cfgByte7 == WRAP_16)
                    readAddr[3:0] <= readAddr[3:0] + 4'h1;
                else if (cfgByte7 == WRAP_32)
                    readAddr[4:0] <= readAddr[4:0] + 5'h1;
                else
                    readAddr[5:0] <= readAddr[5:0] + 6'h1;
            end
        end
    end

    // First nibble of an aligned 8-byte granule
    assign granuleStart = rdValid && !nibblePhase_reg &&
        readAddr[2:0] == 3'h0;

    // Correction pin delay and drive, held until the next granule or read starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            delayCnt_reg <= 4'h0;
            pinLow_reg <= 1'b0;
        end else if (cmdRead) begin
            delayCnt_reg <= 4'h0;
            pinLow_reg <= 1'b0;
        end else if (granuleStart) begin
            pinLow_reg <= 1'b0;
            delayCnt_reg <= granuleFix ? 4'(CORR_DELAY) : 4'h0;
        end else if (delayCnt_reg != 4'h0) begin
            delayCnt_reg <= delayCnt_reg - 4'h1;
            if (delayCnt_reg == 4'h1)
                pinLow_reg <= 1'b1;
        end
    end
    assign correctionSignal_n = 1'b0;
    assign correctionSignalOe_n = !pinLow_reg;

    // CRC enable and chunk size, overridden by wrap length
    assign crcEnable = dtrMode && cfgByte4[7:6] != CRC_OFF;
    assign chunkCode = (wrapRead_reg && crcEnable) ?
        wrapChunk(cfgByte7) : cfgByte4[7:6];

    // Per-line chunk XOR generator
    fsi_crc_chunk crcGen (
        .clk(clk),
        .rst_n(rst_n),
        .restart(cmdRead),
        .enable(crcEnable),
        .sizeCode(chunkCode),
        .dataValid(rdValid),
        .dataLines(rdLines),
        .crcValid(crcValid),
        .crcData(crcData)
    );

    // Register images
    assign statusProtectReg = {statusLockSelLo_reg, blockProtect_reg,
        writeEnableLatch_reg, op_reg != OP_IDLE};
    assign operationFlagReg = {op_reg == OP_IDLE, flags_reg[FL_EHELD],
        flags_reg[FL_EFAIL], flags_reg[FL_PFAIL], 1'b0,
        flags_reg[FL_PHELD], flags_reg[FL_PROT], addr4_reg};
    assign upperAddressReg = {singleFixFlag_reg, 3'h0, upperAddr_reg};

    // Assertions
    busy_tracks_op_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmdAccept && statusWriteCmd |=> statusProtectReg[ST_BUSY])
        else $error("busy bit not set after accepted write");
    wel_gates_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        anyWrite && !statusProtectReg[ST_WEL] |-> !cmdAccept)
        else $error("write accepted without enable latch");
    chip_erase_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmdChipErase && statusProtectReg[5:2] != 4'h0 |-> !cmdAccept)
        else $error("chip erase accepted while protected");
    lock_both_a: assert property (@(posedge clk) disable iff (!rst_n)
        statusProtectReg[ST_LOCK_LO] && statusLockSelHi && statusWriteCmd
        |=> $stable(statusProtectReg[7:2]))
        else $error("status changed while permanently locked");
    suspend_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        op_reg == OP_PROG && cmdSuspend && !arrayDone && !arrayFail &&
        !cmdSoftReset |=> operationFlagReg[FL_PHELD] &&
        !operationFlagReg[FL_READY])
        else $error("program suspend flag missing");
    fix_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        cmdRead && !(rdValid && granuleFix) |=> !upperAddressReg[UA_FIX])
        else $error("correction flag survived a new read");
    pin_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        granuleStart && granuleFix && !cmdRead ##1 !granuleStart[*2]
        |=> !correctionSignalOe_n)
        else $error("correction pin not driven after delay");
    upper_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cmdUpperWrite && !cmdSoftReset |=> $stable(upperAddressReg[3:0]))
        else $error("upper address changed without write");
    crc_dtr_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        !dtrMode [*2] |-> !crcValid)
        else $error("CRC emitted in single-rate mode");
endmodule : fsi_regs

// *** fsi_host_model.sv ***
`timescale 1ns/1ps
// Host side of the open-drain correction pin, with its pull-up
module fsi_host_model (
    input wire logic pinOe_n,
    input wire logic pinOut,
    output wire logic pinLevel
);
    // Pull-up wins whenever the device lets go of the pin
    assign pinLevel = pinOe_n ? 1'b1 : pinOut;
endmodule : fsi_host_model

// *** fsi_regs_bench.sv ***
`timescale 1ns/1ps
module fsi_regs_bench;
    import fsi_pkg::*;
    logic clk = 0, rst_n = 0, wp_n = 1, dtr = 0, wrap = 0, fix = 0;
    logic lockHi = 0, otp = 0;
    logic [7:0] cfg5 = 8'hff;
    logic accSeen, refSeen, refuse;
    logic [27:0] rdA;
    logic [19:0] cmd = '0;
    logic [7:0] cfg4 = 8'hff, cfg7 = 8'hff, stData = 8'h00, upData = 8'h00;
    logic [3:0] lines = 4'h0;
    logic [7:0] st, fl, ua;
    logic acc, oe_n, pinOut, pin, crcV, at3;
    logic [3:0] crcD, x;
    int mismatches = 0, num_checks = 0, hits;
    fsi_regs i_dut (.clk(clk), .rst_n(rst_n), .writeProtect_n(wp_n),
        .statusLockSelHi(lockHi), .cfgByte4(cfg4), .cfgByte5(cfg5),
        .cfgByte7(cfg7), .dtrMode(dtr), .cmdWren(cmd[0]), .cmdWrdi(cmd[1]),
        .statusWriteCmd(cmd[2]), .statusWriteData(stData),
        .cmdConfigWrite(cmd[3]), .cmdProgram(cmd[4]),
        .cmdOtpProgram(cmd[5]), .otpLocked(otp), .cmdSectorErase(cmd[6]),
        .cmdBlockErase(cmd[7]), .cmdChipErase(cmd[8]), .cmdAddr(28'h0),
        .cmdSuspend(cmd[9]), .cmdResume(cmd[10]), .cmdSoftReset(cmd[11]),
        .cmdEnter4Byte(cmd[12]), .cmdExit4Byte(cmd[13]),
        .cmdUpperWrite(cmd[14]), .cmdUpperData(upData), .cmdRead(cmd[15]),
        .cmdReadWrap(wrap), .progByte(cmd[16]), .arrayDone(cmd[17]),
        .arrayFail(cmd[18]), .rdValid(cmd[19]), .rdLines(lines),
        .granuleFix(fix), .statusProtectReg(st), .operationFlagReg(fl),
        .upperAddressReg(ua), .cmdAccept(acc), .cmdRefuse(refuse),
        .opAddr(), .progAddr(), .readAddr(rdA),
        .correctionSignal_n(pinOut),
        .correctionSignalOe_n(oe_n), .crcValid(crcV), .crcData(crcD));
    fsi_host_model i_host (.pinOe_n(oe_n), .pinOut(pinOut), .pinLevel(pin));
    // Free-running 100 MHz clock
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle command pulse, accept sampled mid-cycle
    task automatic pulse(input int b);
        @(posedge clk);
        #1 cmd[b] = 1'b1;
        #4 accSeen = acc;
        refSeen = refuse;
        @(posedge clk);
        #1 cmd[b] = 1'b0;
    endtask : pulse
    // Back-to-back nibbles after a new read; CRC pulses counted on the way
    task automatic stream(input int n);
        pulse(15);
        x = 4'h0;
        hits = 0;
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            #1 hits += int'(crcV === 1'b1);
            if (k == 3) at3 = pin;
            cmd[19] = 1'b1;
            lines = (k == 1) ? 4'ha : k[3:0];
            x ^= lines;
            fix = (k < 16);
        end
        @(posedge clk);
        #1 cmd[19] = 1'b0;
        fix = 1'b0;
    endtask : stream
    task automatic write_status(input logic [7:0] d);
        stData = d;
        pulse(0);
        pulse(2);
        pulse(17);
    endtask : write_status
    task automatic print_verdict;
        if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Cuts a hang short
    initial begin
        #300000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        chk(st, 8'h00);
        chk(fl, 8'h80);
        chk(ua, 8'h00);
        chk({7'h0, pin}, 8'h01);
        pulse(4);
        chk({7'h0, accSeen}, 8'h00);
        pulse(0);
        chk(st, 8'h02);
        pulse(4);
        chk({7'h0, accSeen}, 8'h01);
        chk(st, 8'h01);
        chk({7'h0, fl[FL_READY]}, 8'h00);
        pulse(9);
        chk({7'h0, fl[FL_PHELD]}, 8'h01);
        pulse(10);
        chk({7'h0, fl[FL_PHELD]}, 8'h00);
        pulse(17);
        chk(st, 8'h00);
        write_status(8'h04);
        chk(st, 8'h04);
        pulse(0);
        pulse(8);
        chk({6'h0, accSeen, refSeen}, 8'h01);
        chk({6'h0, fl[FL_EFAIL], fl[FL_PROT]}, 8'h03);
        write_status(8'h80);
        wp_n = 1'b0;
        pulse(0);
        pulse(2);
        chk({7'h0, accSeen}, 8'h00);
        wp_n = 1'b1;
        stData = 8'h00;
        pulse(2);
        chk({7'h0, accSeen}, 8'h01);
        pulse(17);
        chk(st, 8'h00);
        // Erase suspended, resumed, then failing
        pulse(0);
        pulse(6);
        pulse(9);
        chk({7'h0, fl[FL_EHELD]}, 8'h01);
        pulse(10);
        chk({5'h0, fl[6:5], fl[1]}, 8'h00);
        pulse(18);
        chk({6'h0, fl[FL_READY], fl[FL_EFAIL]}, 8'h03);
        upData = 8'h85;
        pulse(14);
        chk(ua, 8'h05);
        pulse(15);
        chk(rdA[27:20], 8'h50);
        pulse(12);
        chk({7'h0, fl[FL_ADDR4]}, 8'h01);
        pulse(15);
        chk(rdA[27:20], 8'h00);
        pulse(11);
        chk({fl[FL_ADDR4], ua[UA_FIX], 2'h0, ua[3:0]}, 8'h00);
        // Configuration byte five forces four-byte mode
        cfg5 = ADDR4_CFG;
        pulse(13);
        chk({7'h0, fl[FL_ADDR4]}, 8'h01);
        cfg5 = 8'hff;
        pulse(13);
        chk({7'h0, fl[FL_ADDR4]}, 8'h00);
        dtr = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cfg4 = {CRC_16 - 2'(i), 6'h3f};
            stream(32 << i);
            chk({hits[2:0], crcV, crcD}, {3'h0, 1'b1, x});
            chk({7'h0, ua[UA_FIX]}, 8'h01);
            chk({6'h0, at3, pin}, 8'h01);
        end
        cfg4 = {CRC_16, 6'h3f};
        cfg7 = WRAP_32;
        wrap = 1'b1;
        stream(64);
        chk({hits[2:0], crcV, crcD}, {3'h0, 1'b1, x});
        wrap = 1'b0;
        dtr = 1'b0;
        stream(64);
        chk({3'h0, hits[3:0], crcV}, 8'h00);
        // Locked one-time space refuses a program
        otp = 1'b1;
        pulse(0);
        pulse(5);
        chk({5'h0, accSeen, fl[FL_PFAIL], fl[FL_PROT]}, 8'h03);
        // Both lock selects set: status writes refused for good
        write_status(8'h80);
        lockHi = 1'b1;
        stData = 8'h00;
        pulse(0);
        pulse(2);
        chk({6'h0, accSeen, refSeen}, 8'h01);
        chk(st, 8'h82);
        print_verdict();
    end
endmodule : fsi_regs_bench
